// ### test_host_transfer_error_handling.sv
// Testbench joining the host controller and the unit over the refresh-time link.
// Assumes the unit number is 5 and software drives the host through its plain port.
`timescale 1ns/10ps
module test_host_transfer_error_handling;
	logic        mclk;
	logic        rst;
	logic [3:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        irq;
	logic        prog_req;
	logic        prog_done;
	logic        xfer_err;
	logic [15:0] st;
	int          err_count;
	int          n_tests;

	xfer_link_if link ();
	assign link.my_unit = 4'h5;
	xfer_unit i_xfer_unit (.mclk(mclk), .rst(rst), .link(link), .prog_req(prog_req),
		.prog_done(prog_done), .xfer_err(xfer_err));
	xfer_host i_xfer_host (.mclk(mclk), .rst(rst), .link(link), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
	xfer_link_sva #(.AREA(xfer_pkg::AREA_WORDS)) i_xfer_link_sva (.mclk(mclk), .rst(rst),
		.refresh(link.refresh), .req(link.req), .code(link.code), .unit_no(link.unit_no),
		.count(link.count), .addr(link.addr), .unit_busy(link.unit_busy), .ack(link.ack),
		.ok(link.ok), .status_word(link.status_word), .my_unit(link.my_unit));

	// ==========================================================
	// Port access and comparison
	task automatic chk(input logic [15:0] s, input logic [15:0] e, input string n);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, output logic [15:0] d);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// Busy takes a cycle or two to show after go, so the poll starts late.
	task automatic wait_idle;
		repeat (3) @(posedge mclk);
		for (int i = 0; i < 40; i++) begin
			rreg(4'h5, st);
			if (st[0] === 1'b0) break;
		end
	endtask
	task automatic run(input logic [15:0] c, d0, d1, a, ctl);
		wreg(4'h1, c);
		wreg(4'h2, d0);
		wreg(4'h3, d1);
		wreg(4'h4, a);
		wreg(4'h0, ctl);
		wait_idle;
	endtask
	task automatic prog_pulse(input int n, input logic done);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			if (done) prog_done <= 1'b1;
			else prog_req <= 1'b1;
			@(posedge mclk);
			prog_done <= 1'b0;
			prog_req <= 1'b0;
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_refresh_good;
		run(16'h1000, 16'h5005, 16'h0000, 16'h0000, 16'h0001);
		chk(st[0], 1'b1, "busy_no_refresh");
		wreg(4'h0, 16'h0004);
		wait_idle;
		chk(st[2:1], 2'b10, "eq_exec");
		chk(xfer_err, 1'b0, "flag_good");
	endtask
	task automatic t_sticky;
		run(16'h3000, 16'h5001, 16'h0000, 16'h0000, 16'h0005);
		chk(xfer_err, 1'b1, "flag_code");
		rreg(4'h9, st);
		chk(st, 16'h0001 << xfer_pkg::XFER_ERR_BIT, "unit_word");
		run(16'h1000, 16'h5003, 16'h0000, 16'h0000, 16'h0005);
		chk(xfer_err, 1'b1, "flag_sticky");
		run(16'hec00, 16'h5002, 16'h0000, 16'h0000, 16'h0005);
		chk(st[2:1], 2'b01, "clear_bad_count");
		chk(xfer_err, 1'b1, "flag_kept");
		run(16'hec00, 16'h5001, 16'h0000, 16'h0000, 16'h0005);
		chk(xfer_err, 1'b0, "flag_clear_old");
	endtask
	task automatic t_three_word;
		run(16'h1010, 16'h0005, 16'h0004, 16'h0000, 16'h0007);
		chk(xfer_err, 1'b1, "flag_count3");
		run(16'hec00, 16'h0005, 16'h0001, 16'h0000, 16'h0007);
		chk(xfer_err, 1'b0, "flag_clear_new");
		run(16'h2010, 16'h0005, 16'h0006, 16'h0000, 16'h0007);
		chk(xfer_err, 1'b0, "flag_data_free");
	endtask
	task automatic t_range;
		run(16'h1000, 16'h5002, 16'h0000, 16'h1fff, 16'h0005);
		chk(xfer_err, 1'b1, "flag_range");
		run(16'hec00, 16'h5001, 16'h0000, 16'h0000, 16'h0005);
		run(16'h1000, 16'h5002, 16'h0000, 16'h1ffe, 16'h0005);
		chk(xfer_err, 1'b0, "flag_edge");
	endtask
	task automatic t_overflow;
		prog_pulse(3, 1'b0);
		// The flag is launched by the edge the pulse task returns on, so look just after it.
		#1;
		chk(xfer_err, 1'b1, "flag_overflow");
		chk(link.unit_busy, 1'b1, "busy_full");
		prog_pulse(2, 1'b1);
		#1;
		chk(link.unit_busy, 1'b0, "busy_freed");
		run(16'hec00, 16'h5001, 16'h0000, 16'h0000, 16'h0005);
		chk(xfer_err, 1'b0, "flag_after_ovf");
	endtask
	task automatic t_exec_irq;
		wreg(4'h8, 16'h0000);
		run(16'h1000, 16'h5000, 16'h0000, 16'h0000, 16'h0005);
		chk(st[2:1], 2'b01, "exec_zero");
		run(16'h1000, 16'h3001, 16'h0000, 16'h0000, 16'h0005);
		chk(st[2:1], 2'b01, "exec_no_unit");
		chk(irq, 1'b0, "irq_masked");
		wreg(4'h8, 16'h0002);
		repeat (2) @(posedge mclk);
		chk(irq, 1'b1, "irq_raised");
		wreg(4'h7, 16'h0002);
		rreg(4'h6, st);
		chk(st[2:0], 3'b101, "irq_stat_clr");
		chk(irq, 1'b0, "irq_cleared");
	endtask

	// ==========================================================
	// Clock, reset, sequence and verdict
	task automatic results;
		if (err_count == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		#200000;
		err_count++;
		results;
	end
	initial begin
		rst = 1'b1;
		addr = 4'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		prog_req = 1'b0;
		prog_done = 1'b0;
		err_count = 0;
		n_tests = 0;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		t_refresh_good;
		t_sticky;
		t_three_word;
		t_range;
		t_overflow;
		t_exec_irq;
		results;
	end
endmodule

// ### xfer_host.sv
// Host end: runs one word-transfer instruction per software go, during refresh.
// Assumes a software port with read data one cycle after the read strobe.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/10ps
module xfer_host (
	input  wire logic  mclk,
	input  wire logic  rst,
	xfer_link_if.host  link,
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [15:0]      rdata,
	output logic             irq
);

	typedef enum {S_IDLE, S_WAIT, S_ISSUE, S_DONE} hstate_t;

	// ==========================================================
	// Registers and instruction sequencing
	hstate_t     state;
	hstate_t     next_state;
	logic [2:0]  ctrl;
	logic [2:0]  next_ctrl;
	logic [15:0] code;
	logic [15:0] next_code;
	logic [15:0] dest;
	logic [15:0] next_dest;
	logic [15:0] dest1;
	logic [15:0] next_dest1;
	logic [15:0] taddr;
	logic [15:0] next_taddr;
	logic        exec_err;
	logic        next_exec_err;
	logic        eq;
	logic        next_eq;
	logic [2:0]  istat;
	logic [2:0]  next_istat;
	logic [2:0]  ien;
	logic [2:0]  next_ien;
	logic [15:0] unit_word;
	logic [15:0] next_unit_word;
	logic [15:0] next_rdata;
	logic        req;
	logic        next_req;
	logic [3:0]  unit_no;
	logic [7:0]  count;
	logic        op_bad;
	logic [2:0]  ev;

	function automatic logic is_bcd(input logic [11:0] v);
		is_bcd = (v[3:0] < 4'd10) && (v[7:4] < 4'd10) && (v[11:8] < 4'd10);
	endfunction

	always_comb begin
		// Operand decode for the selected family.
		if (ctrl[xfer_pkg::CTRL_NEWFAM]) begin
			unit_no = dest[3:0];
			count   = dest1[7:0];
			op_bad  = (dest[15:4] != 12'h000) || (dest1 == 16'h0000) ||
				(dest1 > 16'(xfer_pkg::MAX_WORDS));
			if (code == xfer_pkg::CODE_CLEAR_ERR) begin
				op_bad = op_bad || (dest1 != xfer_pkg::CLEAR_COUNT_NEW);
			end
		end else begin
			unit_no = dest[15:12];
			count   = 8'(dest[11:8]) * 8'd100 + 8'(dest[7:4]) * 8'd10 + 8'(dest[3:0]);
			op_bad  = !is_bcd(dest[11:0]) || (dest[11:0] == 12'h000) ||
				(dest[11:0] > 12'h128);
			if (code == xfer_pkg::CODE_CLEAR_ERR) begin
				op_bad = op_bad || (dest[11:0] != xfer_pkg::CLEAR_COUNT_OLD);
			end
		end
	end

	always_comb begin
		next_state     = state;
		next_ctrl      = ctrl;
		next_code      = code;
		next_dest      = dest;
		next_dest1     = dest1;
		next_taddr     = taddr;
		next_exec_err  = exec_err;
		next_eq        = eq;
		next_ien       = ien;
		next_req       = 1'b0;
		next_unit_word = unit_word;
		ev             = 3'b000;
		next_ctrl[xfer_pkg::CTRL_GO_BIT] = 1'b0;
		if (link.ack) begin
			next_unit_word = link.status_word;
		end
		if (link.ack && link.status_word[xfer_pkg::XFER_ERR_BIT]) begin
			ev[xfer_pkg::IRQ_UNITERR] = 1'b1;
		end
		if (wr) begin
			unique case (addr)
				xfer_pkg::ADDR_CTRL:   next_ctrl  = wdata[2:0];
				xfer_pkg::ADDR_CODE:   next_code  = wdata;
				xfer_pkg::ADDR_DEST:   next_dest  = wdata;
				xfer_pkg::ADDR_DEST1:  next_dest1 = wdata;
				xfer_pkg::ADDR_ADDR:   next_taddr = wdata;
				xfer_pkg::ADDR_IRQ_EN: next_ien   = wdata[2:0];
				default: ;
			endcase
		end
		unique case (state)
			S_IDLE: begin
				if (ctrl[xfer_pkg::CTRL_GO_BIT]) begin
					if (op_bad) begin
						next_exec_err = 1'b1;
						next_eq       = 1'b0;
						ev[xfer_pkg::IRQ_ERR_BIT] = 1'b1;
					end else begin
						next_exec_err = 1'b0;
						next_state    = S_WAIT;
					end
				end
			end
			S_WAIT: begin
				if (ctrl[xfer_pkg::CTRL_REFRESH] && !link.unit_busy) begin
					next_req   = 1'b1;
					next_state = S_ISSUE;
				end
			end
			S_ISSUE: begin
				next_state = S_DONE;
			end
			S_DONE: begin
				if (link.ack) begin
					next_eq       = link.ok;
					next_exec_err = !link.ok;
					ev[xfer_pkg::IRQ_DONE_BIT] = 1'b1;
					ev[xfer_pkg::IRQ_ERR_BIT]  = !link.ok;
					next_state    = S_IDLE;
				end else begin
					next_exec_err = 1'b1;
					next_eq       = 1'b0;
					ev[xfer_pkg::IRQ_ERR_BIT] = 1'b1;
					next_state    = S_IDLE;
				end
			end
		endcase
		next_istat = istat;
		if (wr && addr == xfer_pkg::ADDR_IRQ_CLR) begin
			next_istat = istat & ~wdata[2:0];
		end
		next_istat = next_istat | ev;
		next_rdata = 16'h0000;
		if (rd) begin
			unique case (addr)
				xfer_pkg::ADDR_CTRL:      next_rdata = {13'h0000, ctrl};
				xfer_pkg::ADDR_CODE:      next_rdata = code;
				xfer_pkg::ADDR_DEST:      next_rdata = dest;
				xfer_pkg::ADDR_DEST1:     next_rdata = dest1;
				xfer_pkg::ADDR_ADDR:      next_rdata = taddr;
				xfer_pkg::ADDR_STATUS:    next_rdata = {13'h0000, eq, exec_err,
					state != S_IDLE};
				xfer_pkg::ADDR_IRQ_STAT:  next_rdata = {13'h0000, istat};
				xfer_pkg::ADDR_IRQ_EN:    next_rdata = {13'h0000, ien};
				xfer_pkg::ADDR_UNIT_WORD: next_rdata = unit_word;
				default:                  next_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state     <= S_IDLE;
			ctrl      <= 3'b000;
			code      <= 16'h0000;
			dest      <= 16'h0000;
			dest1     <= 16'h0000;
			taddr     <= 16'h0000;
			exec_err  <= 1'b0;
			eq        <= 1'b0;
			istat     <= 3'b000;
			ien       <= 3'b000;
			unit_word <= 16'h0000;
			rdata     <= 16'h0000;
			req       <= 1'b0;
			irq       <= 1'b0;
		end else begin
			state     <= next_state;
			ctrl      <= next_ctrl;
			code      <= next_code;
			dest      <= next_dest;
			dest1     <= next_dest1;
			taddr     <= next_taddr;
			exec_err  <= next_exec_err;
			eq        <= next_eq;
			istat     <= next_istat;
			ien       <= next_ien;
			unit_word <= next_unit_word;
			rdata     <= next_rdata;
			req       <= next_req;
			irq       <= |(next_istat & next_ien);
		end
	end

	always_comb begin
		link.refresh = ctrl[xfer_pkg::CTRL_REFRESH];
		link.req     = req;
		link.code    = code;
		link.unit_no = unit_no;
		link.count   = count;
		link.addr    = taddr;
	end

endmodule

// ### xfer_link_if.sv
// Refresh-time link between the host controller and the unit.
// Assumes one shared clock; the host drives requests only during its refresh window.
`timescale 1ns/10ps
interface xfer_link_if;
	logic        refresh;
	logic        req;
	logic [15:0] code;
	logic [3:0]  unit_no;
	logic [7:0]  count;
	logic [15:0] addr;
	logic        unit_busy;
	logic        ack;
	logic        ok;
	logic [15:0] status_word;
	logic [3:0]  my_unit;

	modport host (
		output refresh,
		output req,
		output code,
		output unit_no,
		output count,
		output addr,
		input  unit_busy,
		input  ack,
		input  ok,
		input  status_word
	);
	modport unit (
		input  refresh,
		input  req,
		input  code,
		input  unit_no,
		input  count,
		input  addr,
		output unit_busy,
		output ack,
		output ok,
		output status_word,
		input  my_unit
	);
endinterface

// ### xfer_link_sva.sv
// Checker for the refresh-time link between the host controller and the unit.
// Assumes it watches the interface signals and is placed beside the link in the testbench.
`timescale 1ns/10ps
module xfer_link_sva #(
	parameter logic [15:0] AREA = xfer_pkg::AREA_WORDS
) (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        refresh,
	input wire logic        req,
	input wire logic [15:0] code,
	input wire logic [3:0]  unit_no,
	input wire logic [7:0]  count,
	input wire logic [15:0] addr,
	input wire logic        unit_busy,
	input wire logic        ack,
	input wire logic        ok,
	input wire logic [15:0] status_word,
	input wire logic [3:0]  my_unit
);
	// ==========================================================
	// Decoding of a taken request
	logic taken;
	logic known;
	logic three;
	logic over;
	logic bad;
	logic cause;
	logic flag;
	assign taken = refresh && req && unit_no == my_unit;
	assign known = code inside {16'h1000, 16'h1010, 16'h2000, 16'h2010, 16'hec00};
	assign three = code == xfer_pkg::CODE_WRITE_3W || code == xfer_pkg::CODE_READ_3W;
	assign over  = ({1'b0, addr} + {9'h000, count}) > {1'b0, AREA};
	assign bad   = !known || (three && count % 8'd3 != 8'd0) || over || unit_busy;
	assign cause = (taken && bad) || unit_busy;
	assign flag  = status_word[xfer_pkg::XFER_ERR_BIT];

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence s_take;
		taken;
	endsequence
	sequence s_clear;
		taken && code == xfer_pkg::CODE_CLEAR_ERR && !bad;
	endsequence
	sequence s_answer;
		ack && ok;
	endsequence

	// ==========================================================
	// Properties
	a_clear_drops_flag: assert property (s_clear |=> !flag)
		else $error("clear code left the error flag set");
	a_unknown_code_sets: assert property ((taken && !known) |=> flag)
		else $error("unsupported code did not set the error flag");
	a_count_mult_three: assert property ((taken && three && count % 8'd3 != 8'd0) |=> flag)
		else $error("bad three-word count did not set the error flag");
	a_range_sets_flag: assert property ((taken && over) |=> flag)
		else $error("out of range transfer did not set the error flag");
	a_busy_sets_flag: assert property ((taken && unit_busy) |=> flag)
		else $error("overflowed request did not set the error flag");
	a_flag_has_cause: assert property ($rose(flag) |-> $past(cause))
		else $error("error flag rose without a cause");
	a_flag_stays_set: assert property ((flag && !(taken && code == 16'hec00)) |=> flag)
		else $error("error flag dropped without a clear code");
	a_good_gets_ok: assert property ((s_take ##0 !bad) |=> s_answer)
		else $error("good request not answered with ok");
	a_req_in_refresh: assert property (req |-> refresh)
		else $error("request outside the refresh window");
	a_ack_has_request: assert property (ack |-> $past(taken))
		else $error("answer without a taken request");
endmodule

// ### xfer_pkg.sv
// Shared constants for the host word-transfer link and the unit's error checker.
// Assumes both ends run on one clock, mclk, with a synchronous active-high reset.
package xfer_pkg;

	// ==========================================================
	// Control codes and operand layout
	localparam logic [15:0] CODE_CLEAR_ERR    = 16'hEC00;
	localparam logic [15:0] CODE_WRITE_1W     = 16'h1000;
	localparam logic [15:0] CODE_WRITE_3W     = 16'h1010;
	localparam logic [15:0] CODE_READ_1W      = 16'h2000;
	localparam logic [15:0] CODE_READ_3W      = 16'h2010;
	localparam logic [11:0] CLEAR_COUNT_OLD   = 12'h001;
	localparam logic [15:0] CLEAR_COUNT_NEW   = 16'h0001;
	localparam logic [7:0]  MAX_WORDS         = 8'd128;
	localparam int          STATUS_WORD_OFS   = 7;
	localparam int          XFER_ERR_BIT      = 7;

	// ==========================================================
	// Software port map of the host controller
	localparam logic [3:0] ADDR_CTRL      = 4'h0;
	localparam logic [3:0] ADDR_CODE      = 4'h1;
	localparam logic [3:0] ADDR_DEST      = 4'h2;
	localparam logic [3:0] ADDR_DEST1     = 4'h3;
	localparam logic [3:0] ADDR_ADDR      = 4'h4;
	localparam logic [3:0] ADDR_STATUS    = 4'h5;
	localparam logic [3:0] ADDR_IRQ_STAT  = 4'h6;
	localparam logic [3:0] ADDR_IRQ_CLR   = 4'h7;
	localparam logic [3:0] ADDR_IRQ_EN    = 4'h8;
	localparam logic [3:0] ADDR_UNIT_WORD = 4'h9;
	localparam int         CTRL_GO_BIT    = 0;
	localparam int         CTRL_NEWFAM    = 1;
	localparam int         CTRL_REFRESH   = 2;
	localparam int         ST_BUSY_BIT    = 0;
	localparam int         ST_ERR_BIT     = 1;
	localparam int         ST_EQ_BIT      = 2;
	localparam int         IRQ_DONE_BIT   = 0;
	localparam int         IRQ_ERR_BIT    = 1;
	localparam int         IRQ_UNITERR    = 2;

	// ==========================================================
	// Unit resources
	localparam logic [15:0] AREA_WORDS    = 16'h2000;
	localparam int          SLOT_DEPTH    = 2;

endpackage

// ### xfer_unit.sv
// Unit end: checks each host transfer request and keeps the transfer error flag.
// Assumes the host keeps requests inside its refresh window and the link on mclk.
//
// Overview of operation
// - Clear code resets the transfer error flag.
// - Older host: clear destination is unit, count 001.
// - Newer host: unit in low digit, count 0001.
// - Unsupported control code sets the error flag.
// - Three-word count not multiple of three errs.
// - Start address plus count out of range errs.
// - Too many pending transfers sets the error flag.
// - Flag stays low without any error condition.
// - Data contents are never checked, only count/address.
// - Host raises execution error on bad operands.
// - Host equals flag shows an ok answer to any transfer or clear.
// - Transfers happen only during host refresh.
`timescale 1ns/10ps
module xfer_unit #(
	parameter logic [15:0] AREA = xfer_pkg::AREA_WORDS,
	parameter int          SLOTS = xfer_pkg::SLOT_DEPTH
) (
	input  wire logic mclk,
	input  wire logic rst,
	xfer_link_if.unit link,
	input  wire logic prog_req,
	input  wire logic prog_done,
	output logic      xfer_err
);

	// ==========================================================
	// Request checking
	logic        err;
	logic        next_err;
	logic        ack;
	logic        next_ack;
	logic        ok;
	logic        next_ok;
	logic [2:0]  pending;
	logic [2:0]  next_pending;
	logic        bad;
	logic        three_word;
	logic        known;
	logic [16:0] end_addr;

	always_comb begin
		three_word   = (link.code == xfer_pkg::CODE_WRITE_3W) ||
			(link.code == xfer_pkg::CODE_READ_3W);
		known        = three_word || (link.code == xfer_pkg::CODE_WRITE_1W) ||
			(link.code == xfer_pkg::CODE_READ_1W);
		end_addr     = {1'b0, link.addr} + {9'h000, link.count};
		next_err     = err;
		next_ack     = 1'b0;
		next_ok      = 1'b0;
		next_pending = pending;
		bad          = 1'b0;
		// Only bookkeeping of program transfers; contents are never inspected.
		if (prog_done && pending != 3'd0) begin
			next_pending = pending - 3'd1;
		end
		if (prog_req) begin
			if (next_pending >= 3'(SLOTS)) begin
				bad = 1'b1;
			end else begin
				next_pending = next_pending + 3'd1;
			end
		end
		if (link.refresh && link.req && link.unit_no == link.my_unit) begin
			next_ack = 1'b1;
			if (link.code == xfer_pkg::CODE_CLEAR_ERR) begin
				next_ok = 1'b1;
			end else begin
				if (!known) begin
					bad = 1'b1;
				end else if (three_word && (link.count % 8'd3) != 8'd0) begin
					bad = 1'b1;
				end else if (end_addr > {1'b0, AREA}) begin
					bad = 1'b1;
				end else if (pending >= 3'(SLOTS)) begin
					bad = 1'b1;
				end
				next_ok = !bad;
			end
		end
		// A new error in the clear cycle wins over the clear.
		if (bad) begin
			next_err = 1'b1;
		end else if (next_ack && link.code == xfer_pkg::CODE_CLEAR_ERR) begin
			next_err = 1'b0;
		end
		// Otherwise the flag simply holds, low until an error occurs.
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			err     <= 1'b0;
			ack     <= 1'b0;
			ok      <= 1'b0;
			pending <= 3'd0;
		end else begin
			err     <= next_err;
			ack     <= next_ack;
			ok      <= next_ok;
			pending <= next_pending;
		end
	end

	always_comb begin
		link.ack         = ack;
		link.ok          = ok;
		link.unit_busy   = (pending >= 3'(SLOTS));
		link.status_word = 16'h0000;
		link.status_word[xfer_pkg::XFER_ERR_BIT] = err;
	end

	assign xfer_err = err;

endmodule
